// *** hdl/otpg_ch_if.sv ***
// Interface: shared controls from the top to each channel generator
`timescale 1ns/1ps
`default_nettype none
interface otpg_ch_if;
  import otpg_pkg::*;
  logic       adv;
  logic       line_start;
  logic       mode_enter;
  otpg_mode_e mode;
  logic       framed;
  otpg_slot_e slot;
  logic [9:0] train;
  logic       crc_seed;
  logic       out8;
  modport top (output adv, line_start, mode_enter, mode, framed, slot, train, crc_seed,
               out8);
  modport ch  (input  adv, line_start, mode_enter, mode, framed, slot, train, crc_seed,
               out8);
endinterface : otpg_ch_if
`default_nettype wire

// *** hdl/otpg_channel.sv ***
// Module: one data channel pattern generator with line CRC
`timescale 1ns/1ps
`default_nettype none
module otpg_channel
  import otpg_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  // Shared controls
  otpg_ch_if.ch           ctl,
  // Per channel data
  input  wire logic [9:0] pattern_in,
  input  wire logic [9:0] adc_in,
  output logic      [9:0] word_out
);
  import otpg_pkg::*;

  typedef struct packed {
    logic [9:0] inc;
    logic [9:0] lfsr;
    logic [9:0] crc;
    logic [9:0] word;
  } otpg_chst_s;

  otpg_chst_s st_r, st_nxt;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [9:0] otpg_crc_step(input logic [9:0] c, input logic [9:0] d);
    logic [9:0] r;
    r = c;
    for (int i = 9; i >= 0; i--) begin
      if (r[9] ^ d[i]) begin
        r = {r[8:0], 1'b0} ^ CRC_POLY;
      end else begin
        r = {r[8:0], 1'b0};
      end
    end
    return r;
  endfunction : otpg_crc_step

  function automatic logic [9:0] otpg_lfsr_step(input logic [9:0] l);
    return {l[8:0], ^(l & LFSR_TAPS)};
  endfunction : otpg_lfsr_step

  // ==========================================================================
  // Next state
  // ==========================================================================
  logic [9:0] gen;
  logic [9:0] full;
  always_comb begin
    st_nxt = st_r;
    gen    = adc_in;
    case (ctl.mode)
      OTPG_MODE_FIXED: gen = pattern_in;
      OTPG_MODE_INC:   gen = st_r.inc;
      OTPG_MODE_PRBS:  gen = st_r.lfsr;
      default:         gen = adc_in;
    endcase
    full = st_r.word;
    if (ctl.mode_enter) begin
      st_nxt.inc  = pattern_in;
      st_nxt.lfsr = pattern_in;
    end else if (ctl.adv) begin
      if (!ctl.framed || ctl.mode == OTPG_MODE_NORMAL) begin
        full = gen;
      end else begin
        case (ctl.slot)
          OTPG_SLOT_DATA: full = gen;
          OTPG_SLOT_CRC:  full = (ctl.mode == OTPG_MODE_PRBS) ? st_r.lfsr : st_r.crc;
          default:        full = ctl.train;
        endcase
      end
      if (ctl.framed && ctl.mode == OTPG_MODE_NORMAL && ctl.slot == OTPG_SLOT_IDLE) begin
        full = ctl.train;
      end else if (ctl.framed && ctl.mode == OTPG_MODE_NORMAL && ctl.slot == OTPG_SLOT_CRC) begin
        full = st_r.crc;
      end
      // Ramp and PRBS move on every word except framed idle (training) slots
      if (!ctl.framed || ctl.slot != OTPG_SLOT_IDLE) begin
        st_nxt.lfsr = otpg_lfsr_step(st_r.lfsr);
        if (ctl.framed && ctl.line_start) begin
          st_nxt.inc = pattern_in + 10'h001;
        end else if (st_r.inc == WORD_MAX) begin
          st_nxt.inc = pattern_in;
        end else begin
          st_nxt.inc = st_r.inc + 10'h001;
        end
      end
      if (ctl.line_start && ctl.framed && ctl.mode == OTPG_MODE_INC) begin
        full = pattern_in;
      end
      // CRC over data words only, seeded at line start
      if (ctl.line_start) begin
        st_nxt.crc = otpg_crc_step({WORD_W{ctl.crc_seed}}, full);
      end else if (ctl.slot == OTPG_SLOT_DATA) begin
        st_nxt.crc = otpg_crc_step(st_r.crc, full);
      end
      st_nxt.word = ctl.out8 ? {full[9:2], 2'b00} : full;
    end
    word_out = st_r.word;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= '{inc: 10'h000, lfsr: 10'h001, crc: 10'h000, word: TRAIN_DEFAULT};
    end else begin
      st_r <= st_nxt;
    end
  end

  a_inc_wrap: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ctl.adv && !ctl.mode_enter && !ctl.framed && st_r.inc == WORD_MAX)
    |=> st_r.inc == $past(pattern_in))
    else $error("ramp did not reload start word");
  a_fixed_word: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ctl.adv && !ctl.mode_enter && !ctl.framed && !ctl.out8 && ctl.mode == OTPG_MODE_FIXED)
    |=> st_r.word == $past(pattern_in))
    else $error("fixed word wrong");
  a_eight_bit: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ctl.adv && ctl.out8) |=> st_r.word[1:0] == 2'b00)
    else $error("low bits not dropped in 8-bit mode");
  a_train_idle: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ctl.adv && !ctl.mode_enter && ctl.framed && !ctl.out8 && ctl.slot == OTPG_SLOT_IDLE)
    |=> st_r.word == $past(ctl.train))
    else $error("training word missing outside window");
  a_prbs_move: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ctl.adv && !ctl.mode_enter && !ctl.framed)
    |=> st_r.lfsr == otpg_lfsr_step($past(st_r.lfsr)))
    else $error("prbs did not advance");
  c_inc_wrap: cover property (@(posedge clk_in) ctl.mode == OTPG_MODE_INC && st_r.inc == WORD_MAX);
  c_crc_slot: cover property (@(posedge clk_in) ctl.adv && ctl.slot == OTPG_SLOT_CRC);
endmodule : otpg_channel
`default_nettype wire

// *** hdl/otpg_pkg.sv ***
// Package: constants and types for the output test pattern generator
package otpg_pkg;
  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int          WORD_W         = 10;
  localparam int          OUT8_W         = 8;
  localparam logic [9:0]  TRAIN_DEFAULT  = 10'h3a6;
  localparam logic [9:0]  WORD_MAX       = 10'h3ff;
  localparam logic [9:0]  CRC_POLY       = 10'h24f;
  localparam logic [9:0]  LFSR_TAPS      = 10'h240;
  localparam int          CFG_ADDR_FIRST = 144;
  localparam int          CFG_ADDR_LAST  = 150;
  localparam int          NUM_CH_DEF     = 4;

  // ==========================================================================
  // Stream slot kinds and pattern modes
  // ==========================================================================
  typedef enum logic [1:0] {
    OTPG_SLOT_IDLE,
    OTPG_SLOT_DATA,
    OTPG_SLOT_CRC
  } otpg_slot_e;

  typedef enum logic [1:0] {
    OTPG_MODE_NORMAL,
    OTPG_MODE_FIXED,
    OTPG_MODE_INC,
    OTPG_MODE_PRBS
  } otpg_mode_e;
endpackage : otpg_pkg

// *** hdl/otpg_top.sv ***
// Module: output test pattern generator for all data channels
// Operation
// - 8-bit mode: generate as 10-bit, then drop two low bits.
// - Only data channels get patterns; sync and clock untouched.
// - Framed: pattern only inside windows, training words outside.
// - Fixed and ramp patterns get a real line CRC in its slot.
// - PRBS select wins; else synthetic select with ramp select; else normal.
// - Unframed: data channels continuously carry pattern, no training.
// - Sync channel keeps its timing codes while sequencer enabled.
// - Patterns injected per data channel, no demultiplexing needed.
// - Fixed mode repeats each channel's own word every cycle.
// - Ramp mode adds one per output cycle from the start word.
// - Ramp reloads start word after reaching maximum.
// - Framed ramp also reloads start word at each line start.
// - PRBS seed is each channel's own pattern word.
// - PRBS puts one more random word in the CRC slot.
// - Test configuration lives at addresses 144 to 150.
// - 10-bit CRC seeded per line, updated only on data words.
// - Training word is programmable, default 0x3a6.
`timescale 1ns/1ps
`default_nettype none
module otpg_top
  import otpg_pkg::*;
#(
  parameter int NUM_CH = otpg_pkg::NUM_CH_DEF
)(
  // Clock and reset
  input  wire logic                     CLK_IN,
  input  wire logic                     RESETN_IN,
  // Output word clock from the serialiser
  input  wire logic                     WORD_CLK_IN,
  // Configuration held at addresses 144 to 150
  input  wire logic                     PRBS_EN_IN,
  input  wire logic                     SYNTH_EN_IN,
  input  wire logic                     RAMP_EN_IN,
  input  wire logic                     FRAMED_IN,
  input  wire logic                     OUT8_IN,
  input  wire logic                     CRC_SEED_IN,
  input  wire logic [9:0]               TRAIN_WORD_IN,
  input  wire logic [NUM_CH*10-1:0]     PATTERN_IN,
  // Readout stream from the sequencer
  input  wire logic [NUM_CH*10-1:0]     ADC_DATA_IN,
  input  wire logic [9:0]               SYNC_CODE_IN,
  input  wire logic [1:0]               SLOT_IN,
  input  wire logic                     LINE_START_IN,
  // Serial channel words
  output logic      [NUM_CH*10-1:0]     DATA_OUT,
  output logic      [9:0]               SYNC_OUT,
  output logic                          WORD_STB_OUT
);
  import otpg_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [1:0] wclk_sync;
    logic       wclk_prev;
    logic [1:0] mode;
    logic [9:0] sync;
    logic       stb;
  } otpg_st_s;

  otpg_st_s   st_r, st_nxt;
  otpg_mode_e mode_sel;
  logic       adv;

  otpg_ch_if  chif ();

  // Word clock is foreign: two flops, then edge detect on the second
  assign adv = st_r.wclk_sync[1] && !st_r.wclk_prev;

  always_comb begin
    if (PRBS_EN_IN) begin
      mode_sel = OTPG_MODE_PRBS;
    end else if (SYNTH_EN_IN) begin
      mode_sel = RAMP_EN_IN ? OTPG_MODE_INC : OTPG_MODE_FIXED;
    end else begin
      mode_sel = OTPG_MODE_NORMAL;
    end
    st_nxt           = st_r;
    st_nxt.wclk_sync = {st_r.wclk_sync[0], WORD_CLK_IN};
    st_nxt.wclk_prev = st_r.wclk_sync[1];
    st_nxt.mode      = mode_sel;
    st_nxt.stb       = adv;
    if (adv) begin
      st_nxt.sync = SYNC_CODE_IN;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      st_r <= '{wclk_sync: 2'b00, wclk_prev: 1'b0, mode: 2'b00, sync: TRAIN_DEFAULT,
                stb: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Shared channel controls
  // ==========================================================================
  assign chif.adv        = adv;
  assign chif.line_start = LINE_START_IN;
  assign chif.mode_enter = (mode_sel != otpg_mode_e'(st_r.mode));
  assign chif.mode       = mode_sel;
  assign chif.framed     = FRAMED_IN;
  assign chif.slot       = otpg_slot_e'(SLOT_IN);
  assign chif.train      = TRAIN_WORD_IN;
  assign chif.crc_seed   = CRC_SEED_IN;
  assign chif.out8       = OUT8_IN;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    otpg_channel u_ch (
      .clk_in     (CLK_IN),
      .resetn_in  (RESETN_IN),
      .ctl        (chif),
      .pattern_in (PATTERN_IN[g*10 +: 10]),
      .adc_in     (ADC_DATA_IN[g*10 +: 10]),
      .word_out   (DATA_OUT[g*10 +: 10])
    );
  end

  assign SYNC_OUT     = st_r.sync;
  assign WORD_STB_OUT = st_r.stb;

  a_sync_pass: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    adv |=> SYNC_OUT == $past(SYNC_CODE_IN))
    else $error("sync channel altered");
  a_prbs_first: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    PRBS_EN_IN |-> chif.mode == OTPG_MODE_PRBS)
    else $error("prbs select not prioritised");
  a_strobe_edge: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    $rose(st_r.wclk_sync[1]) |=> WORD_STB_OUT ##1 !WORD_STB_OUT)
    else $error("word strobe wrong");
  c_prbs: cover property (@(posedge CLK_IN) chif.mode == OTPG_MODE_PRBS && adv);
  c_framed: cover property (@(posedge CLK_IN) FRAMED_IN && adv && SLOT_IN == 2'd1);
endmodule : otpg_top
`default_nettype wire

// *** test/otpg_rx_model.sv ***
// Receiver model: captures every channel word on each strobe
`timescale 1ns/1ps
`default_nettype none
module otpg_rx_model #(
  parameter int NUM_CH = 2
)(
  // Clock and capture
  input  wire logic                 clk_in,
  input  wire logic                 stb_in,
  input  wire logic [NUM_CH*10-1:0] data_in,
  input  wire logic [9:0]           sync_in,
  // Captured words
  output logic      [NUM_CH*10-1:0] data_out,
  output logic      [9:0]           sync_out,
  output logic                      got_out
);
  // ==========================================================================
  // Capture
  // ==========================================================================
  // Channel words taken whole, no pixel reordering
  always @(posedge clk_in) begin
    got_out <= stb_in;
    if (stb_in) begin
      data_out <= data_in;
      sync_out <= sync_in;
    end
  end
endmodule : otpg_rx_model
`default_nettype wire

// *** test/tb_top.sv ***
// Testbench: table rows and hand tests for the pattern generator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import otpg_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  typedef struct packed {
    logic [4:0]  m;
    logic [19:0] p;
    logic [1:0]  s;
    logic [19:0] e;
  } otpg_tb_row_s;
  logic         clk = 1'h0, rstn = 1'h0, wclk = 1'h0, ls = 1'h0, seed = 1'h1;
  logic         prbs = 1'h0, synth = 1'h0, ramp = 1'h0, framed = 1'h0, out8 = 1'h0;
  logic         stb, got;
  logic [1:0]   slot = 2'h1;
  logic [9:0]   train = TRAIN_DEFAULT, syn = 10'h2c5, c0, c1, rx_s, sout;
  logic [19:0]  pat = 20'h0, adc = 20'h1234a, d, q, rx_d, dout;
  int           fails = 0, total_checks = 0;
  otpg_tb_row_s rows[7] = '{'{5'h00, 20'h0, 2'h1, 20'h1234a},
    '{5'h04, 20'h0, 2'h1, 20'h1234a}, '{5'h08, 20'h5a5a5, 2'h1, 20'h5a5a5},
    '{5'h08, 20'h5a5a5, 2'h0, 20'h5a5a5}, '{5'h09, 20'hfffff, 2'h1, 20'hff3fc},
    '{5'h0a, 20'h0, 2'h0, 20'he9ba6}, '{5'h0b, 20'h0, 2'h0, 20'he93a4}};
  always #50 clk = ~clk;
  // Word clock phase offset keeps its edges off the system clock edges; its period is eight system clocks
  initial begin
    #130;
    forever #400 wclk = ~wclk;
  end
  otpg_top #(.NUM_CH(2)) dut_u (.CLK_IN(clk), .RESETN_IN(rstn), .WORD_CLK_IN(wclk),
    .PRBS_EN_IN(prbs), .SYNTH_EN_IN(synth), .RAMP_EN_IN(ramp), .FRAMED_IN(framed),
    .OUT8_IN(out8), .CRC_SEED_IN(seed), .TRAIN_WORD_IN(train), .PATTERN_IN(pat),
    .ADC_DATA_IN(adc), .SYNC_CODE_IN(syn), .SLOT_IN(slot), .LINE_START_IN(ls),
    .DATA_OUT(dout), .SYNC_OUT(sout), .WORD_STB_OUT(stb));
  otpg_rx_model #(.NUM_CH(2)) rx_u (.clk_in(clk), .stb_in(stb), .data_in(dout),
    .sync_in(sout), .data_out(rx_d), .sync_out(rx_s), .got_out(got));
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One word: inputs set at a falling edge, capture flag read on falling edges
  task automatic step(input logic [1:0] s, input logic l, output logic [19:0] w);
    int n;
    n = 0;
    @(negedge clk);
    slot = s;
    ls = l;
    do begin
      @(negedge clk);
      n++;
    end while (got !== 1'h1 && n < 20);
    if (got !== 1'h1) fails++;
    w = rx_d;
    chk("sync word", {10'h0, rx_s}, {10'h0, syn});
  endtask : step
  // Passing through normal mode forces a reload well before the next word edge
  task automatic mode(input logic [4:0] m, input logic [19:0] p);
    logic [19:0] x;
    {prbs, synth, ramp, framed, out8} = 5'h0;
    step(2'h1, 1'h0, x);
    {prbs, synth, ramp, framed, out8} = m;
    pat = p;
  endtask : mode
  // Ten bit shift register with feedback x^10+x^7+1
  function automatic logic [9:0] prbs_up(input logic [9:0] l);
    return {l[8:0], l[9] ^ l[6]};
  endfunction : prbs_up
  function automatic logic [9:0] crc_up(input logic [9:0] c, input logic [9:0] w);
    for (int i = 9; i >= 0; i--) c = {c[8:0], 1'h0} ^ ((c[9] ^ w[i]) ? CRC_POLY : 10'h0);
    return c;
  endfunction : crc_up
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    #300000;
    fails++;
    conclude();
  end
  initial begin
    repeat (12) @(negedge clk);
    chk("reset data", dout, 20'he9ba6);
    chk("reset sync", {10'h0, sout}, 20'h3a6);
    chk("reset strobe", {19'h0, stb}, 20'h0);
    rstn = 1'h1;
    step(2'h1, 1'h0, d);
    $display("Test reset done");
    foreach (rows[i]) begin
      mode(rows[i].m, rows[i].p);
      repeat (2) begin
        step(rows[i].s, 1'h0, d);
        chk("table word", d, rows[i].e);
      end
    end
    $display("Test table done");
    mode(5'h0c, {10'h100, 10'h3fd});
    for (int k = 0; k < 4; k++) begin
      step(2'h1, 1'h0, d);
      q = {10'h100 + 10'(k), (k == 3) ? 10'h3fd : 10'h3fd + 10'(k)};
      chk("ramp word", d, q);
    end
    $display("Test ramp done");
    train = 10'h155;
    mode(5'h0e, {10'h010, 10'h200});
    c0 = 10'h3ff;
    c1 = 10'h3ff;
    step(2'h0, 1'h0, d);
    chk("training", d, {2{10'h155}});
    for (int k = 0; k < 3; k++) begin
      step(2'h1, k == 0, d);
      q = {10'h010 + 10'(k), 10'h200 + 10'(k)};
      chk("framed ramp", d, q);
      c0 = crc_up(c0, q[9:0]);
      c1 = crc_up(c1, q[19:10]);
    end
    step(2'h2, 1'h0, d);
    chk("line crc", d, {c1, c0});
    step(2'h1, 1'h1, d);
    chk("line restart", d, {10'h010, 10'h200});
    $display("Test framed done");
    // Seeds kept nonzero so the sequence stays random
    mode(5'h1c, {10'h2aa, 10'h001});
    step(2'h1, 1'h0, q);
    chk("prbs seed", q, {10'h2aa, 10'h001});
    for (int k = 0; k < 3; k++) begin
      step(2'h1, 1'h0, d);
      chk("prbs moves", {19'h0, d != q && d[9:0] != d[19:10]}, 20'h1);
      chk("prbs step", d, {prbs_up(q[19:10]), prbs_up(q[9:0])});
      q = d;
    end
    mode(5'h12, {10'h2aa, 10'h001});
    step(2'h1, 1'h1, q);
    step(2'h2, 1'h0, d);
    chk("prbs crc slot", {19'h0, d != q}, 20'h1);
    chk("prbs crc word", d, {prbs_up(q[19:10]), prbs_up(q[9:0])});
    $display("Test prbs done");
    // Mid-run reset: outputs return to idle, generators reload on release
    rstn = 1'h0;
    @(negedge clk);
    chk("mid reset data", dout, {2{TRAIN_DEFAULT}});
    chk("mid reset sync", {10'h0, sout}, {10'h0, TRAIN_DEFAULT});
    chk("mid reset strobe", {19'h0, stb}, 20'h0);
    rstn = 1'h1;
    step(2'h1, 1'h0, d);
    chk("prbs reseed", d, {10'h2aa, 10'h001});
    $display("Test mid reset done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
